// [rtl/aes_regs_defs.svh]
`ifndef AES_REGS_DEFS_SVH
`define AES_REGS_DEFS_SVH
// Byte offsets on the register bus
`define OFS_CTRL 8'h00
`define OFS_MODE 8'h04
`define OFS_IEN 8'h10
`define OFS_IDIS 8'h14
`define OFS_IMASK 8'h18
`define OFS_ISTAT 8'h1C
`define OFS_KEY 8'h20
`define OFS_IDATA 8'h40
`define OFS_ODATA 8'h50
`define OFS_IV 8'h60
`define OFS_RCNT 8'h84
`define OFS_RNCNT 8'h88
`define OFS_TCNT 8'h8C
`define OFS_TNCNT 8'h90
// Control register bits
`define CTRL_START 0
`define CTRL_SOFT_RESET_CMD 8
// Mode register fields
`define MODE_SMOD 8
`define MODE_LOD 15
`define MODE_RESET 32'h0000_0000
// Start mode codes
`define SMOD_MANUAL 2'h0
`define SMOD_AUTO 2'h1
`define SMOD_DMA 2'h2
// Status and mask bit positions
`define ST_RDY 0
`define ST_RX_TRANSFER_END_FLAG 1
`define ST_TX_TRANSFER_END_FLAG 2
`define ST_RXFULL 3
`define ST_TXEMPTY 4
`define ST_ILL 8
`define ST_KIND 12
`define IRQ_BITS 32'h0000_011F
`define CNT_RESET 16'h0000
`endif

// [rtl/aes_regs_pkg.sv]
package aes_regs_pkg;
  // Illegal access codes
  typedef enum logic [2:0] {
    ILL_IN_DMA = 3'h0,
    ILL_OUT_BUSY = 3'h1,
    ILL_MODE_BUSY = 3'h2,
    ILL_OUT_SUBKEY = 3'h3,
    ILL_MODE_SUBKEY = 3'h4,
    ILL_WO_READ = 3'h5
  } ill_kind_t;
  // Four words, word one in the top slot
  typedef logic [0:3][31:0] block_t;
  // Status from the cipher core
  typedef struct packed {
    logic busy;
    logic subkey;
    logic done;
  } core_status_t;
  // Commands to the cipher core
  typedef struct packed {
    logic start;
    logic flush;
    logic [31:0] mode;
  } core_ctrl_t;
endpackage

// [rtl/aes_status_regs.sv]
`timescale 1ns/1ns
`include "aes_regs_defs.svh"
// Overview of operation
// R1: Mask register reads back enabled sources
// R2: Core completion sets result valid flag
// R3: Start or soft reset clears result valid
// R4: Last output 0: output read clears it; in DMA mode an output read leaves it set and the block start clears it instead
// R5: Last output 1: input write clears it; in DMA mode an input write leaves it set and the block start clears it instead
// R6: Rx count reaching zero sets rx end
// R7: Tx count reaching zero sets tx end
// R8: Rx full when both rx counts zero
// R9: Tx empty when both tx counts zero
// R10: Illegal access flag sticky until soft reset
// R11: Three bit code classifies illegal access
// R12: Kind holds latest code, soft reset clears
// R13: Key is four words, word one first
// R14: Key words never read back
// R15: Input block is four words, one first
// R16: Input words never read back
// R17: Result in four read only words
// R18: Init vector four words, word one first
// R19: Software writes vector only where needed
// R20: Interrupt when a flag and mask meet
module aes_status_regs #(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_dma_step,
  input wire logic tx_dma_step,
  input wire aes_regs_pkg::core_status_t core_st,
  input wire aes_regs_pkg::block_t core_result,
  output aes_regs_pkg::core_ctrl_t core_ctl,
  output aes_regs_pkg::block_t key_block,
  output aes_regs_pkg::block_t data_block,
  output aes_regs_pkg::block_t iv_block,
  output logic irq
);
  import aes_regs_pkg::*;

  // Window match on the upper address nibble
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a[7:4] == base[7:4]);
  endfunction

  // Registers that software may only write
  function automatic logic is_wo(input logic [7:0] a);
    is_wo = (a == `OFS_CTRL) || (a == `OFS_IEN) || (a == `OFS_IDIS)
      || hit(a, `OFS_KEY) || hit(a, `OFS_IDATA) || hit(a, `OFS_IV);
  endfunction

  // Any decoded register
  function automatic logic mapped(input logic [7:0] a);
    mapped = is_wo(a) || (a == `OFS_MODE) || (a == `OFS_IMASK)
      || (a == `OFS_ISTAT) || hit(a, `OFS_ODATA)
      || (a == `OFS_RCNT) || (a == `OFS_RNCNT)
      || (a == `OFS_TCNT) || (a == `OFS_TNCNT);
  endfunction

  logic [31:0] mode; // Mode register
  logic [31:0] next_mode;
  logic [31:0] imask; // Enabled sources
  logic [31:0] next_imask;
  logic rdy; // Result valid flag
  logic next_rdy;
  logic rx_end; // Rx transfer end
  logic next_rx_end;
  logic tx_end; // Tx transfer end
  logic next_tx_end;
  logic ill; // Illegal access seen
  logic next_ill;
  logic [2:0] kind; // Latest illegal kind
  logic [2:0] next_kind;
  logic [CNT_W-1:0] rcnt; // Rx count
  logic [CNT_W-1:0] next_rcnt;
  logic [CNT_W-1:0] rncnt; // Rx next count
  logic [CNT_W-1:0] next_rncnt;
  logic [CNT_W-1:0] tcnt; // Tx count
  logic [CNT_W-1:0] next_tcnt;
  logic [CNT_W-1:0] tncnt; // Tx next count
  logic [CNT_W-1:0] next_tncnt;
  logic [3:0] in_seen; // Input words written
  logic [3:0] next_in_seen;
  block_t out_w; // Result words
  block_t next_out_w;
  block_t next_key;
  block_t next_data;
  block_t next_iv;
  core_ctrl_t next_ctl;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  logic [31:0] status; // Composed status word
  logic acc; // Access completes this edge
  logic wr; // Write completes
  logic rd; // Read completes
  logic [1:0] idx; // Word within a window
  logic dma; // DMA start mode
  logic last_output_mode; // Last output mode
  logic bad; // Illegal access this edge
  ill_kind_t bad_kind; // Its code

  // Status word from flags and counters
  // Buffer flags are pure decodes of the counters, no stored state
  always_comb begin
    status = 32'h0000_0000;
    status[`ST_RDY] = rdy;
    status[`ST_RX_TRANSFER_END_FLAG] = rx_end;
    status[`ST_TX_TRANSFER_END_FLAG] = tx_end;
    status[`ST_RXFULL] = (rcnt == '0) && (rncnt == '0); // R8
    status[`ST_TXEMPTY] = (tcnt == '0) && (tncnt == '0); // R9
    status[`ST_ILL] = ill;
    status[`ST_KIND +: 3] = kind;
  end

  // Next values of all register state
  always_comb begin
    next_mode = mode;
    next_imask = imask;
    next_rdy = rdy;
    next_rx_end = rx_end;
    next_tx_end = tx_end;
    next_ill = ill;
    next_kind = kind;
    next_rcnt = rcnt;
    next_rncnt = rncnt;
    next_tcnt = tcnt;
    next_tncnt = tncnt;
    next_in_seen = in_seen;
    next_out_w = out_w;
    next_key = key_block;
    next_data = data_block;
    next_iv = iv_block;
    next_ctl = core_ctl;
    next_ctl.start = 1'b0;
    next_ctl.flush = 1'b0;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    acc = psel && penable && pready;
    wr = acc && pwrite;
    rd = acc && !pwrite;
    idx = paddr[3:2];
    dma = (mode[`MODE_SMOD +: 2] == `SMOD_DMA);
    last_output_mode = mode[`MODE_LOD];
    bad = 1'b0;
    bad_kind = ILL_WO_READ;
    // One wait state, then answer
    next_pready = psel && penable && !pready;

    // Read data latched with pready
    if (psel && penable && !pready) begin
      next_pslverr = !mapped(paddr);
      next_prdata = 32'h0000_0000; // Write only reads as zero
      if (paddr == `OFS_MODE) begin
        next_prdata = mode;
      end else if (paddr == `OFS_IMASK) begin
        next_prdata = imask; // R1
      end else if (paddr == `OFS_ISTAT) begin
        next_prdata = status;
      end else if (hit(paddr, `OFS_ODATA)) begin
        next_prdata = out_w[idx]; // R17
      end else if (paddr == `OFS_RCNT) begin
        next_prdata = 32'(rcnt);
      end else if (paddr == `OFS_RNCNT) begin
        next_prdata = 32'(rncnt);
      end else if (paddr == `OFS_TCNT) begin
        next_prdata = 32'(tcnt);
      end else if (paddr == `OFS_TNCNT) begin
        next_prdata = 32'(tncnt);
      end
    end

    // Classify illegal accesses
    // Later checks override earlier ones: a write-only read ranks first
    if (wr && hit(paddr, `OFS_IDATA) && dma && core_st.busy) begin
      bad = 1'b1; // R11
      bad_kind = ILL_IN_DMA;
    end
    if (rd && hit(paddr, `OFS_ODATA)) begin
      if (core_st.subkey) begin
        bad = 1'b1; // R11
        bad_kind = ILL_OUT_SUBKEY;
      end else if (core_st.busy) begin
        bad = 1'b1; // R11
        bad_kind = ILL_OUT_BUSY;
      end
    end
    if (wr && paddr == `OFS_MODE) begin
      if (core_st.subkey) begin
        bad = 1'b1; // R11
        bad_kind = ILL_MODE_SUBKEY;
      end else if (core_st.busy) begin
        bad = 1'b1; // R11
        bad_kind = ILL_MODE_BUSY;
      end
    end
    if (rd && is_wo(paddr)) begin
      bad = 1'b1; // R11
      bad_kind = ILL_WO_READ; // R14 R16
    end

    // Register writes
    if (wr) begin
      if (paddr == `OFS_MODE) begin
        next_mode = pwdata;
      end else if (paddr == `OFS_IEN) begin
        next_imask = imask | (pwdata & `IRQ_BITS);
      end else if (paddr == `OFS_IDIS) begin
        next_imask = imask & ~pwdata;
      end else if (hit(paddr, `OFS_KEY)) begin
        next_key[idx] = pwdata; // R13
      end else if (hit(paddr, `OFS_IV)) begin
        next_iv[idx] = pwdata; // R18
      end else if (hit(paddr, `OFS_IDATA)) begin
        next_data[idx] = pwdata; // R15
        next_in_seen[idx] = 1'b1;
        if (last_output_mode && !dma) begin
          next_rdy = 1'b0; // R5
        end
      end else if (paddr == `OFS_RCNT) begin
        next_rcnt = pwdata[CNT_W-1:0];
        next_rx_end = 1'b0; // R6
      end else if (paddr == `OFS_RNCNT) begin
        next_rncnt = pwdata[CNT_W-1:0];
        next_rx_end = 1'b0; // R6
      end else if (paddr == `OFS_TCNT) begin
        next_tcnt = pwdata[CNT_W-1:0];
        next_tx_end = 1'b0; // R7
      end else if (paddr == `OFS_TNCNT) begin
        next_tncnt = pwdata[CNT_W-1:0];
        next_tx_end = 1'b0; // R7
      end else if (paddr == `OFS_CTRL) begin
        if (pwdata[`CTRL_START]) begin
          next_rdy = 1'b0; // R3
          // Only manual mode starts from here
          next_ctl.start = (mode[`MODE_SMOD +: 2] == `SMOD_MANUAL);
        end
      end
    end

    // Output read clears in manual and auto when last output is 0
    if (rd && hit(paddr, `OFS_ODATA) && !last_output_mode && !dma) begin
      next_rdy = 1'b0; // R4
    end

    // Auto and DMA start on a full input block
    if (!(mode[`MODE_SMOD +: 2] == `SMOD_MANUAL) && (&next_in_seen)) begin
      next_ctl.start = 1'b1;
      next_in_seen = 4'h0;
      if (dma) begin
        next_rdy = 1'b0; // R4
      end
    end else if (next_ctl.start) begin
      next_in_seen = 4'h0;
    end

    // DMA channels step their counters
    // A step beats a counter write in the same cycle, so software
    // should not rewrite a counter while its channel is still moving
    if (rx_dma_step && rcnt != '0) begin
      next_rcnt = rcnt - 1'b1;
      if (rcnt == CNT_W'(1)) begin
        next_rx_end = 1'b1; // R6
      end
    end else if (rcnt == '0 && rncnt != '0) begin
      // Reload from the next count
      next_rcnt = rncnt;
      next_rncnt = '0;
    end
    if (tx_dma_step && tcnt != '0) begin
      next_tcnt = tcnt - 1'b1;
      if (tcnt == CNT_W'(1)) begin
        next_tx_end = 1'b1; // R7
      end
    end else if (tcnt == '0 && tncnt != '0) begin
      next_tcnt = tncnt;
      next_tncnt = '0;
    end

    // Soft reset clears the interface state
    if (wr && paddr == `OFS_CTRL && pwdata[`CTRL_SOFT_RESET_CMD]) begin
      next_ctl.flush = 1'b1;
      next_ctl.start = 1'b0;
      next_rdy = 1'b0; // R3
      next_ill = 1'b0; // R10
      next_kind = 3'h0; // R12
      next_mode = `MODE_RESET;
      next_imask = 32'h0000_0000;
      next_in_seen = 4'h0;
      // A step that ends a buffer in this cycle still wins
      next_rx_end = rx_dma_step && (rcnt == CNT_W'(1));
      next_tx_end = tx_dma_step && (tcnt == CNT_W'(1));
    end

    // Illegal access is sticky, last kind kept
    if (bad) begin
      next_ill = 1'b1; // R10
      next_kind = bad_kind; // R12
    end

    // Completion wins over any clear
    if (core_st.done) begin
      next_rdy = 1'b1; // R2
      next_out_w = core_result; // R17
    end

    next_ctl.mode = next_mode;
    // Interrupt from flags under mask
    next_irq = |(status & imask); // R20
  end

  // Register stage, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `MODE_RESET;
      imask <= 32'h0000_0000;
      rdy <= 1'b0;
      rx_end <= 1'b0;
      tx_end <= 1'b0;
      ill <= 1'b0;
      kind <= 3'h0;
      rcnt <= `CNT_RESET;
      rncnt <= `CNT_RESET;
      tcnt <= `CNT_RESET;
      tncnt <= `CNT_RESET;
      in_seen <= 4'h0;
      out_w <= '0;
      key_block <= '0;
      data_block <= '0;
      iv_block <= '0;
      core_ctl <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      mode <= next_mode;
      imask <= next_imask;
      rdy <= next_rdy;
      rx_end <= next_rx_end;
      tx_end <= next_tx_end;
      ill <= next_ill;
      kind <= next_kind;
      rcnt <= next_rcnt;
      rncnt <= next_rncnt;
      tcnt <= next_tcnt;
      tncnt <= next_tncnt;
      in_seen <= next_in_seen;
      out_w <= next_out_w;
      key_block <= next_key;
      data_block <= next_data;
      iv_block <= next_iv;
      core_ctl <= next_ctl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end
endmodule // aes_status_regs

// [verification/aes_regs_monitor.sv]
`timescale 1ns/1ns
`include "aes_regs_defs.svh"
// Bus and output checks on the status block
module aes_regs_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire aes_regs_pkg::core_ctrl_t core_ctl,
  input wire aes_regs_pkg::core_status_t core_st,
  input wire aes_regs_pkg::block_t key_block,
  input wire aes_regs_pkg::block_t data_block,
  input wire aes_regs_pkg::block_t iv_block,
  input wire logic irq
);
  import aes_regs_pkg::*;
  // Commit edge of a transfer
  logic cm;
  assign cm = psel && penable && pready && ce;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  key_word_a: assert property (
    cm && pwrite && paddr == `OFS_KEY |=> key_block[0] == $past(pwdata))
    else $error("key word one not loaded");
  input_word_a: assert property (
    cm && pwrite && paddr == 8'h4C |=> data_block[3] == $past(pwdata))
    else $error("input word four not loaded");
  iv_word_a: assert property (
    cm && pwrite && paddr == `OFS_IV |=> iv_block[0] == $past(pwdata))
    else $error("vector word one not loaded");
  key_hidden_a: assert property (
    cm && !pwrite && paddr[7:4] == 4'h2 |-> prdata == 32'h0)
    else $error("key word readable");
  input_hidden_a: assert property (
    cm && !pwrite && paddr[7:4] == 4'h4 |-> prdata == 32'h0)
    else $error("input word readable");
  manual_start_a: assert property (
    cm && pwrite && paddr == `OFS_CTRL && pwdata[`CTRL_START]
    && core_ctl.mode[9:8] == `SMOD_MANUAL |=> core_ctl.start)
    else $error("manual start not issued");
  mask_clear_a: assert property (
    cm && pwrite && paddr == `OFS_CTRL && pwdata[`CTRL_SOFT_RESET_CMD] |-> ##2 !irq)
    else $error("interrupt survives soft reset");
  soft_flush_a: assert property (
    cm && pwrite && paddr == `OFS_CTRL && pwdata[`CTRL_SOFT_RESET_CMD] |=> core_ctl.flush)
    else $error("soft reset did not flush the core");
  ready_wait_a: assert property (
    psel && $rose(penable) |-> !pready ##1 pready)
    else $error("wait state wrong");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  cover property (core_st.done);
  cover property (cm && pslverr);
  cover property (irq);
endmodule // aes_regs_monitor
bind aes_status_regs aes_regs_monitor i_aes_regs_monitor (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_ctl(core_ctl),
  .core_st(core_st), .key_block(key_block), .data_block(data_block),
  .iv_block(iv_block), .irq(irq));

// [verification/core_model.sv]
`timescale 1ns/1ns
// Behavioural core: subkey phase, then rounds
module core_model #(
  parameter int LAT = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire aes_regs_pkg::core_ctrl_t core_ctl,
  input wire aes_regs_pkg::block_t key_block,
  input wire aes_regs_pkg::block_t data_block,
  output aes_regs_pkg::core_status_t core_st,
  output aes_regs_pkg::block_t core_result
);
  import aes_regs_pkg::*;
  // Cycles left in the block
  int cnt;
  logic done;
  assign core_st = {cnt != 0 && cnt <= LAT, cnt > LAT, done};
  // Flush aborts, start loads the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      done <= 1'b0;
      core_result <= '0;
    end else begin
      if (core_ctl.flush) cnt <= 0;
      else if (core_ctl.start) cnt <= LAT + 4;
      else if (cnt != 0) cnt <= cnt - 1;
      done <= cnt == 1 && !core_ctl.flush;
      // Scrambled outside done, so stale data never passes
      core_result <= cnt == 1 ? key_block ^ data_block : ~core_result;
    end
  end
endmodule // core_model

// [verification/testbench.sv]
`timescale 1ns/1ns
`include "aes_regs_defs.svh"
// Self-checking bench for the status block
module testbench;
  import aes_regs_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic rx = 0, tx = 0, err, irq, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, m, r, prdata;
  logic [31:0] k [4], d [4];
  logic [7:0] ad [5] = '{`OFS_IDATA, `OFS_ODATA, `OFS_MODE, `OFS_ODATA, `OFS_MODE};
  core_status_t core_st;
  core_ctrl_t core_ctl;
  block_t core_result, key_block, data_block, iv_block;
  int failures = 0, compares = 0, seed = 32'hb2e1c649, n;
  always #10 pclk = ~pclk;
  aes_status_regs i_aes_status_regs (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_dma_step(rx), .tx_dma_step(tx),
    .core_st(core_st), .core_result(core_result), .core_ctl(core_ctl),
    .key_block(key_block), .data_block(data_block), .iv_block(iv_block), .irq(irq));
  core_model i_core_model (.pclk(pclk), .presetn(presetn), .core_ctl(core_ctl),
    .key_block(key_block), .data_block(data_block), .core_st(core_st),
    .core_result(core_result));
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 20) failures++;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // DMA step pulses, then time for the reload
  task automatic step(input int c, input int times);
    repeat (times) begin
      @(posedge pclk);
      if (c == 0) rx <= 1'b1;
      else tx <= 1'b1;
      @(posedge pclk);
      rx <= 1'b0;
      tx <= 1'b0;
    end
    repeat (2) @(posedge pclk);
  endtask
  // Poll until result valid, bounded
  task automatic waitrdy;
    n = 0;
    do begin
      apb(1'b0, `OFS_ISTAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 30);
  endtask
  task automatic idle;
    n = 0;
    while ((core_st.busy | core_st.subkey) !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    // A core that never goes idle counts as a mismatch
    if (n >= 100) failures++;
    repeat (3) @(posedge pclk);
  endtask
  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #400000;
    failures++;
    results;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`OFS_IMASK, 32'h0);
    rdchk(`OFS_ISTAT, 32'h18);
    m = $random(seed) & `IRQ_BITS | 32'h1;
    apb(1'b1, `OFS_IEN, m);
    rdchk(`OFS_IMASK, m);
    r = $random(seed);
    apb(1'b1, `OFS_IDIS, r);
    apb(1'b1, `OFS_IEN, 32'h1);
    rdchk(`OFS_IMASK, (m & ~r) | 32'h1);
    apb(1'b0, 8'hF8, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Chained mode first, the vector is never written in codebook mode
    apb(1'b1, `OFS_MODE, 32'h1000);
    for (int i = 0; i < 4; i++) begin
      k[i] = $random(seed);
      d[i] = $random(seed);
      apb(1'b1, 8'(`OFS_KEY + 4 * i), k[i]);
      apb(1'b1, 8'(`OFS_IDATA + 4 * i), d[i]);
      apb(1'b1, 8'(`OFS_IV + 4 * i), $random(seed));
    end
    rdchk(8'h24, 32'h0);
    rdchk(8'h48, 32'h0);
    apb(1'b0, `OFS_ISTAT, 32'h0);
    chk(rd & 32'h7100, 32'h5100);
    apb(1'b1, `OFS_CTRL, 32'h1);
    waitrdy;
    chk(rd & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h1);
    for (int i = 0; i < 4; i++) rdchk(8'(`OFS_ODATA + 4 * i), k[i] ^ d[i]);
    apb(1'b0, `OFS_ISTAT, 32'h0);
    chk(rd & 32'h1, 32'h0);
    // Auto start with last output set
    apb(1'b1, `OFS_MODE, 32'h8100);
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(`OFS_IDATA + 4 * i), $random(seed));
    waitrdy;
    apb(1'b1, `OFS_IDATA, 32'h0);
    apb(1'b0, `OFS_ISTAT, 32'h0);
    chk(rd & 32'h1, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h100);
    rdchk(`OFS_ISTAT, 32'h18);
    rdchk(`OFS_IMASK, 32'h0);
    // Each illegal access kind but write-only read, latest kept
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, `OFS_MODE, c == 0 ? 32'h200 : 32'h0);
      if (c == 0) for (int i = 0; i < 4; i++) apb(1'b1, 8'(`OFS_IDATA + 4 * i), 32'h0);
      else apb(1'b1, `OFS_CTRL, 32'h1);
      if (c < 3) repeat (6) @(posedge pclk);
      apb(c % 2 == 0, ad[c], 32'h0);
      apb(1'b0, `OFS_ISTAT, 32'h0);
      chk(rd & 32'h7100, 32'h100 | (c << 12));
      idle;
    end
    apb(1'b1, `OFS_CTRL, 32'h100);
    // Transfer counters with reload, both channels
    for (int c = 0; c < 2; c++) begin
      n = 1 + ($random(seed) & 3);
      apb(1'b1, c ? `OFS_TCNT : `OFS_RCNT, n);
      apb(1'b1, c ? `OFS_TNCNT : `OFS_RNCNT, 32'h1);
      step(c, n);
      apb(1'b0, `OFS_ISTAT, 32'h0);
      chk(rd & (32'hA << c), 32'h2 << c);
      step(c, 1);
      apb(1'b0, `OFS_ISTAT, 32'h0);
      chk(rd & (32'hA << c), 32'hA << c);
      apb(1'b1, c ? `OFS_TCNT : `OFS_RCNT, 32'h1);
      apb(1'b0, `OFS_ISTAT, 32'h0);
      chk(rd & (32'hA << c), 32'h0);
    end
    results;
  end
endmodule // testbench
